// ---- hdl/wspc_power_ctrl.sv ----
// wspc_power_ctrl: wake signalling, power state and receiver control with wishbone registers
// Functional notes
// [R1] in remote-wake mode an enabled wake event pulls the wake pin low
// [R2] deep-state exit is by reset; power state returns to D0, host reprograms; here a pm register write also leaves D3
// [R3] host leaves wake mode writing zero to power state and wake enable
// [R4] clearing wake signal enable releases the wake pin
// [R5] after leaving D3 operational registers stay locked until config reinitialised
// [R6] host reads wake control status to find the wake cause
// [R7] writing one to wake flag clears pending wake, via either register
// [R8] host clears phy wake cause in the phy interrupt status register
// [R9] host clears every wake control status bit during wake exit
// [R10] host disables receiver, refilters, reloads pointer, then re-enables it
// [R11] receiver re-enable after packet wake drains held packet by dma
// [R12] in sleep mode no wake detection and no service request
// [R13] sleep entry: disable receiver, zero pointer, re-enable receiver
// [R14] sleep entry: no wake events, clear enable, set power state
// [R15] unpowered deep state: host asserts reset, stops clock, removes power
// [R16] sleep exit: zero power state, reconfigure, restart receiver
// [R17] pm register: bit 15 flag w1c, bit 8 enable, bits 1:0 state
// [R18] command bit 3 written one disables the receiver
// [R19] command bit 2 written one enables the receiver
// [R20] wake pin stays low until enable cleared or flag cleared
`timescale 1ns/1ps
`default_nettype none
module wspc_power_ctrl
   import wspc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // wake event detectors, asynchronous levels; bit 0 is the phy interrupt
   input wire logic [WSPC_NUM_EVENTS-1:0] wake_event_in,
   // wake pin, open drain
   output logic wake_signal_pin_n,
   output logic wake_signal_pin_oe,
   // receiver control
   output logic rx_enabled,
   output logic rx_pointer_reload,
   output logic rx_drain_start,
   output logic [31:0] rx_descriptor_pointer,
   // power status
   output logic remote_wake_mode,
   output logic sleep_mode,
   output logic phy_power_on
);
   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic lane_bit(input logic [3:0] sel, input int pos);
      lane_bit = sel[pos / 8];
   endfunction : lane_bit

   function automatic logic is_oper(input logic [7:0] adr);
      is_oper = (adr == WSPC_CMD_OFS) || (adr == WSPC_CCS_OFS) ||
                (adr == WSPC_WCS_OFS) || (adr == WSPC_RX_DESCRIPTOR_POINTER_OFS);
   endfunction : is_oper

   ////////////////////////////////////////////////////////////////////////////////
   // event synchroniser
   logic [WSPC_NUM_EVENTS-1:0] event_sync;

   wspc_sync #(.WIDTH(WSPC_NUM_EVENTS)) u_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .async_in(wake_event_in),
      .sync_out(event_sync)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // state
   logic [1:0] power_state, next_power_state;
   logic wake_signal_enable, next_wake_signal_enable;
   logic wake_signal_flag, next_wake_signal_flag;
   logic [7:0] wake_enables, next_wake_enables;
   logic [7:0] wake_causes, next_wake_causes;
   logic [31:0] next_rx_descriptor_pointer;
   logic next_rx_enabled, next_rx_pointer_reload, next_rx_drain_start;
   logic config_done, next_config_done;
   logic was_deep, next_was_deep;
   wspc_mode_t mode, next_mode;
   logic next_ack;
   logic [31:0] next_dat;

   logic wr, rd_req, locked, wake_armed, in_sleep;
   logic flag_clear;
   logic [7:0] hits, cause_clear;

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      // write lands on the edge where the master samples ack
      wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
      rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
      locked = (mode == WSPC_LOCKED); // R5
      wake_armed = (power_state != WSPC_D0) && wake_signal_enable;
      in_sleep = (power_state != WSPC_D0) && !wake_signal_enable;

      next_power_state = power_state;
      next_wake_signal_enable = wake_signal_enable;
      next_wake_enables = wake_enables;
      next_rx_descriptor_pointer = rx_descriptor_pointer;
      next_rx_enabled = rx_enabled;
      next_rx_pointer_reload = 1'b0;
      next_rx_drain_start = 1'b0;
      next_config_done = config_done;
      next_was_deep = was_deep;
      flag_clear = 1'b0;
      cause_clear = 8'h00;

      if (wr && wb_adr_i == WSPC_PMCS_OFS) begin
         if (lane_bit(wb_sel_i, WSPC_PM_FLAG) && wb_dat_i[WSPC_PM_FLAG]) begin
            flag_clear = 1'b1; // R7 R17
         end
         if (lane_bit(wb_sel_i, WSPC_PM_ENABLE)) begin
            next_wake_signal_enable = wb_dat_i[WSPC_PM_ENABLE]; // R17
         end
         if (lane_bit(wb_sel_i, 0)) begin
            next_power_state = wb_dat_i[WSPC_PM_STATE_HI:0]; // R17
         end
      end
      if (wr && wb_adr_i == WSPC_CFG_OFS && lane_bit(wb_sel_i, WSPC_CFG_DONE)) begin
         next_config_done = wb_dat_i[WSPC_CFG_DONE];
      end
      // operational registers ignore writes while locked
      if (wr && !locked) begin
         case (wb_adr_i)
            WSPC_CMD_OFS: begin
               if (lane_bit(wb_sel_i, 0) && wb_dat_i[WSPC_CMD_RX_DIS]) begin
                  next_rx_enabled = 1'b0; // R18
               end else if (lane_bit(wb_sel_i, 0) && wb_dat_i[WSPC_CMD_RX_EN]) begin
                  next_rx_enabled = 1'b1; // R19
                  next_rx_pointer_reload = 1'b1;
                  next_rx_drain_start = |(wake_causes & WSPC_PACKET_EVENTS); // R11
               end
            end
            WSPC_CCS_OFS: begin
               if (lane_bit(wb_sel_i, WSPC_PM_FLAG) && wb_dat_i[WSPC_PM_FLAG]) begin
                  flag_clear = 1'b1; // R7
               end
            end
            WSPC_WCS_OFS: begin
               if (lane_bit(wb_sel_i, 0)) begin
                  next_wake_enables = wb_dat_i[7:0];
               end
               if (lane_bit(wb_sel_i, WSPC_WCS_CAUSE_LO)) begin
                  cause_clear = wb_dat_i[WSPC_WCS_CAUSE_LO +: 8];
               end
            end
            WSPC_RX_DESCRIPTOR_POINTER_OFS: begin
               for (int b = 0; b < 4; b++) begin
                  if (wb_sel_i[b]) begin
                     next_rx_descriptor_pointer[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                  end
               end
            end
            default: begin
            end
         endcase
      end

      // detection only while armed; sleep detects nothing
      hits = wake_armed ? (event_sync & wake_enables) : 8'h00; // R1 R12
      // a new hit wins over a clear in the same cycle
      next_wake_causes = (wake_causes & ~cause_clear) | hits;
      next_wake_signal_flag = (wake_signal_flag && !flag_clear) || (|hits); // R20

      // leaving D3 for D0 relocks the operational registers
      if (power_state == WSPC_D3) begin
         next_was_deep = 1'b1;
      end
      if (power_state == WSPC_D3 && next_power_state != WSPC_D3) begin
         next_config_done = 1'b0; // R5
      end

      next_mode = mode;
      case (mode)
         WSPC_NORMAL: begin
            if (wake_armed) next_mode = WSPC_WAKE;
            else if (in_sleep) next_mode = WSPC_SLEEP;
         end
         WSPC_WAKE, WSPC_SLEEP: begin
            if (power_state == WSPC_D0) begin
               next_mode = was_deep ? WSPC_LOCKED : WSPC_NORMAL; // R5
               next_was_deep = 1'b0;
            end else if (wake_armed) begin
               next_mode = WSPC_WAKE;
            end else begin
               next_mode = WSPC_SLEEP;
            end
         end
         WSPC_LOCKED: begin
            if (config_done) next_mode = WSPC_NORMAL; // R5
            else if (power_state != WSPC_D0) next_mode = wake_armed ? WSPC_WAKE : WSPC_SLEEP;
         end
         default: next_mode = WSPC_NORMAL;
      endcase

      next_ack = rd_req;
      next_dat = 32'h0000_0000;
      if (rd_req && !(locked && is_oper(wb_adr_i))) begin
         case (wb_adr_i)
            WSPC_CMD_OFS: next_dat[WSPC_CMD_RX_EN] = rx_enabled;
            WSPC_PMCS_OFS, WSPC_CCS_OFS: begin
               next_dat[WSPC_PM_FLAG] = wake_signal_flag;
               next_dat[WSPC_PM_ENABLE] = wake_signal_enable;
               next_dat[WSPC_PM_STATE_HI:0] = power_state;
            end
            WSPC_WCS_OFS: next_dat = {8'h00, wake_causes, 8'h00, wake_enables}; // R6
            WSPC_RX_DESCRIPTOR_POINTER_OFS: next_dat = rx_descriptor_pointer;
            WSPC_CFG_OFS: next_dat[WSPC_CFG_DONE] = config_done;
            default: next_dat = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers; reset loads D0, but a pm register write can also leave the unpowered state
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         power_state <= WSPC_D0; // R2
         wake_signal_enable <= 1'b0;
         wake_signal_flag <= 1'b0;
         wake_enables <= WSPC_WCS_RST;
         wake_causes <= WSPC_WCS_RST;
         rx_descriptor_pointer <= WSPC_RX_DESCRIPTOR_POINTER_RST;
         rx_enabled <= 1'b0;
         rx_pointer_reload <= 1'b0;
         rx_drain_start <= 1'b0;
         config_done <= 1'b0;
         was_deep <= 1'b0;
         mode <= WSPC_NORMAL;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         power_state <= next_power_state;
         wake_signal_enable <= next_wake_signal_enable;
         wake_signal_flag <= next_wake_signal_flag;
         wake_enables <= next_wake_enables;
         wake_causes <= next_wake_causes;
         rx_descriptor_pointer <= next_rx_descriptor_pointer;
         rx_enabled <= next_rx_enabled;
         rx_pointer_reload <= next_rx_pointer_reload;
         rx_drain_start <= next_rx_drain_start;
         config_done <= next_config_done;
         was_deep <= next_was_deep;
         mode <= next_mode;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin and status outputs
   always_comb begin
      // enable gates the pin directly so clearing it releases at once
      wake_signal_pin_oe = wake_signal_flag && wake_signal_enable; // R1 R4 R20
      wake_signal_pin_n = !wake_signal_pin_oe;
      remote_wake_mode = (mode == WSPC_WAKE);
      sleep_mode = (mode == WSPC_SLEEP); // R12
      phy_power_on = !(sleep_mode && power_state == WSPC_D3);
   end
endmodule : wspc_power_ctrl
`default_nettype wire

// ---- hdl/wspc_pkg.sv ----
// wspc_pkg: register map, field positions and state encodings of the wake/sleep power control
package wspc_pkg;
   // register byte offsets on the wishbone bus
   localparam logic [7:0] WSPC_CMD_OFS = 8'h00;
   localparam logic [7:0] WSPC_PMCS_OFS = 8'h04;
   localparam logic [7:0] WSPC_CCS_OFS = 8'h08;
   localparam logic [7:0] WSPC_WCS_OFS = 8'h0c;
   localparam logic [7:0] WSPC_RX_DESCRIPTOR_POINTER_OFS = 8'h10;
   localparam logic [7:0] WSPC_CFG_OFS = 8'h14;
   // command_register fields
   localparam int WSPC_CMD_RX_DIS = 3;
   localparam int WSPC_CMD_RX_EN = 2;
   // pm_control_status / clockrun_control_status fields
   localparam int WSPC_PM_FLAG = 15;
   localparam int WSPC_PM_ENABLE = 8;
   localparam int WSPC_PM_STATE_HI = 1;
   // wake_control_status: enables in low byte, sticky causes in bits 23:16
   localparam int WSPC_WCS_CAUSE_LO = 16;
   localparam int WSPC_NUM_EVENTS = 8;
   localparam logic [7:0] WSPC_PACKET_EVENTS = 8'hfe;
   // config_init field: host marks configuration space as reinitialised
   localparam int WSPC_CFG_DONE = 0;
   // power state encodings
   localparam logic [1:0] WSPC_D0 = 2'h0;
   localparam logic [1:0] WSPC_D3 = 2'h3;
   // reset values
   localparam logic [31:0] WSPC_RX_DESCRIPTOR_POINTER_RST = 32'h0000_0000;
   localparam logic [7:0] WSPC_WCS_RST = 8'h00;
   // power mode state machine, gray along normal -> wake -> sleep -> locked
   typedef enum logic [1:0] {
      WSPC_NORMAL = 2'b00,
      WSPC_WAKE = 2'b01,
      WSPC_SLEEP = 2'b11,
      WSPC_LOCKED = 2'b10
   } wspc_mode_t;
endpackage : wspc_pkg

// ---- hdl/wspc_sync.sv ----
// wspc_sync: two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module wspc_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : wspc_sync
`default_nettype wire

// ---- test/wspc_power_ctrl_sva.sv ----
// wspc_power_ctrl_sva: bus, wake pin and receiver assertions for the power control block
`timescale 1ns/1ps
`default_nettype none
module wspc_power_ctrl_sva
   import wspc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // wake pin and status
   input wire logic wake_signal_pin_n,
   input wire logic wake_signal_pin_oe,
   input wire logic rx_enabled,
   input wire logic rx_drain_start,
   input wire logic remote_wake_mode,
   input wire logic sleep_mode,
   input wire logic phy_power_on
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   logic wr_ok;
   logic wr_cmd;
   logic wr_pm;
   assign wr_ok = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign wr_cmd = wr_ok && wb_adr_i == WSPC_CMD_OFS && wb_sel_i[0];
   // both registers reach the flag, so either may end a hold
   assign wr_pm = wr_ok && wb_sel_i[1] && (wb_adr_i == WSPC_PMCS_OFS || wb_adr_i == WSPC_CCS_OFS);
   ////////////////////////////////////////////////////////////////////////////////
   chk_ack_one:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   chk_ack_next:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   chk_pin_drive:
      assert property (wake_signal_pin_oe != wake_signal_pin_n) else $error("pin enable wrong");
   chk_pin_cause:
      assert property ($fell(wake_signal_pin_n) |-> remote_wake_mode)
         else $error("pin fell outside wake mode");
   chk_pin_holds:
      assert property (!wake_signal_pin_n && !wr_pm |=> !wake_signal_pin_n)
         else $error("pin released without clear");
   chk_pin_release:
      assert property (wr_pm && wb_adr_i == WSPC_PMCS_OFS && !wb_dat_i[WSPC_PM_ENABLE]
         |=> wake_signal_pin_n) else $error("pin held after enable cleared");
   chk_sleep_quiet:
      assert property (sleep_mode && $past(sleep_mode) |-> wake_signal_pin_n)
         else $error("pin low in sleep");
   chk_rx_off:
      assert property ($fell(rx_enabled) |-> $past(wr_cmd && wb_dat_i[WSPC_CMD_RX_DIS]))
         else $error("receiver stopped without disable");
   chk_rx_on:
      assert property ($rose(rx_enabled)
         |-> $past(wr_cmd && wb_dat_i[WSPC_CMD_RX_EN] && !wb_dat_i[WSPC_CMD_RX_DIS]))
         else $error("receiver started without enable");
   chk_drain_cause:
      assert property (rx_drain_start |-> $past(wr_cmd && wb_dat_i[WSPC_CMD_RX_EN]))
         else $error("drain without enable write");
   chk_reset_d0:
      assert property ($rose(resetn) |-> !remote_wake_mode && !sleep_mode && phy_power_on
         && wake_signal_pin_n) else $error("state after reset not normal");
endmodule : wspc_power_ctrl_sva
`default_nettype wire

// ---- test/wspc_host_side.sv ----
// wspc_host_side: wake event sources and the pulled-up wake line on the host board
`timescale 1ns/1ps
`default_nettype none
module wspc_host_side
   import wspc_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // requests from the bench
   input wire logic [WSPC_NUM_EVENTS-1:0] raise,
   input wire logic phy_clear,
   // wake lines
   output logic [WSPC_NUM_EVENTS-1:0] wake_event_in,
   input wire logic pin_n,
   input wire logic pin_oe,
   output logic pin_level
);
   logic phy_irq = 1'b0;
   // phy interrupt is sticky until the host clears it in the phy itself
   always @(posedge ref_clk) begin
      if (raise[0]) begin
         phy_irq <= 1'b1;
      end else if (phy_clear) begin
         phy_irq <= 1'b0;
      end
   end
   assign wake_event_in = {raise[WSPC_NUM_EVENTS-1:1], phy_irq};
   // pull-up holds the line high whenever nobody sinks it
   assign pin_level = pin_oe ? pin_n : 1'b1;
endmodule : wspc_host_side
`default_nettype wire

// ---- test/wspc_power_ctrl_tb.sv ----
// wspc_power_ctrl_tb: register-level tests of wake, sleep and receiver control
`timescale 1ns/1ps
`default_nettype none
module wspc_power_ctrl_tb import wspc_pkg::*;;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rx_descriptor_pointer, q;
   logic [7:0] raise = 8'h00;
   logic [7:0] wake_event_in;
   logic phy_clear = 1'b0;
   logic wb_ack_o, wake_signal_pin_n, wake_signal_pin_oe, pin_level, rx_enabled;
   logic rx_pointer_reload, rx_drain_start, remote_wake_mode, sleep_mode, phy_power_on;
   int mismatches = 0;
   int checks = 0;
   int drains = 0;
   int reloads = 0;
   initial forever #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (rx_drain_start === 1'b1) drains <= drains + 1;
   // pointer reload pulses, counted so every enable write that takes effect can be accounted for
   always @(posedge ref_clk) if (rx_pointer_reload === 1'b1) reloads <= reloads + 1;
   wspc_power_ctrl dut (.ref_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .wake_event_in, .wake_signal_pin_n, .wake_signal_pin_oe,
      .rx_enabled, .rx_pointer_reload, .rx_drain_start, .rx_descriptor_pointer, .remote_wake_mode,
      .sleep_mode, .phy_power_on);
   wspc_host_side host (.ref_clk, .raise, .phy_clear, .wake_event_in, .pin_n(wake_signal_pin_n),
      .pin_oe(wake_signal_pin_oe), .pin_level);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   // one classic cycle; returns one idle edge after ack so results have landed
   task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         close_out();
      end
      @(posedge ref_clk);
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      check(q, e);
   endtask : rd
   task automatic wait_pin(input logic e);
      int n;
      n = 0;
      while (pin_level !== e && n < 12) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 12) begin
         mismatches++;
         close_out();
      end
      check(32'(pin_level), 32'(e));
   endtask : wait_pin
   task automatic fire(input logic [7:0] e, input logic clr);
      raise <= e;
      phy_clear <= clr;
      repeat (3) @(posedge ref_clk);
      raise <= 8'h00;
      phy_clear <= 1'b0;
   endtask : fire
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(WSPC_PMCS_OFS, 32'h0);
      check(32'({wake_signal_pin_n, wake_signal_pin_oe, phy_power_on}), 32'h5);
      wr(WSPC_CMD_OFS, 32'h8);
      wr(WSPC_RX_DESCRIPTOR_POINTER_OFS, 32'h1000);
      wr(WSPC_CMD_OFS, 32'h4);
      check(32'(rx_enabled), 32'h1);
      wr(WSPC_CMD_OFS, 32'hc);
      check(32'(rx_enabled), 32'h0);
      wr(WSPC_WCS_OFS, 32'h3);
      wr(WSPC_PMCS_OFS, 32'h8103);
      // mode register follows the power state one edge later
      @(posedge ref_clk);
      check(32'(remote_wake_mode), 32'h1);
      fire(8'h01, 1'b0);
      wait_pin(1'b0);
      rd(WSPC_WCS_OFS, 32'h0001_0003);
      fire(8'h00, 1'b1);
      check(32'(pin_level), 32'h0);
      wr(WSPC_CCS_OFS, 32'h8100);
      wait_pin(1'b1);
      fire(8'h02, 1'b0);
      wait_pin(1'b0);
      wr(WSPC_PMCS_OFS, 32'h0);
      wait_pin(1'b1);
      rd(WSPC_RX_DESCRIPTOR_POINTER_OFS, 32'h0);
      wr(WSPC_CMD_OFS, 32'h4);
      check(32'(rx_enabled), 32'h0);
      wr(WSPC_CFG_OFS, 32'h1);
      rd(WSPC_RX_DESCRIPTOR_POINTER_OFS, 32'h1000);
      wr(WSPC_CMD_OFS, 32'h8);
      wr(WSPC_RX_DESCRIPTOR_POINTER_OFS, 32'h2000);
      wr(WSPC_CMD_OFS, 32'h4);
      @(posedge ref_clk);
      check(32'(drains), 32'h1);
      check(rx_descriptor_pointer, 32'h2000);
      wr(WSPC_WCS_OFS, 32'h00ff_0000);
      rd(WSPC_WCS_OFS, 32'h0);
      wr(WSPC_CMD_OFS, 32'h8);
      wr(WSPC_RX_DESCRIPTOR_POINTER_OFS, 32'h0);
      wr(WSPC_CMD_OFS, 32'h4);
      check(rx_descriptor_pointer, 32'h0);
      wr(WSPC_PMCS_OFS, 32'h3);
      @(posedge ref_clk);
      check(32'({sleep_mode, phy_power_on}), 32'h2);
      fire(8'h01, 1'b0);
      repeat (6) @(posedge ref_clk);
      check(32'(pin_level), 32'h1);
      fire(8'h00, 1'b1);
      rd(8'h20, 32'h0);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(WSPC_PMCS_OFS, 32'h0);
      check(32'(sleep_mode), 32'h0);
      // shallow sleep at D1 keeps the phy up and leaves registers reachable
      wr(WSPC_PMCS_OFS, 32'h1);
      rd(WSPC_CCS_OFS, 32'h1);
      check(32'({sleep_mode, phy_power_on}), 32'h3);
      wr(WSPC_PMCS_OFS, 32'h0);
      wr(WSPC_CMD_OFS, 32'h8);
      wr(WSPC_RX_DESCRIPTOR_POINTER_OFS, 32'h3000);
      wr(WSPC_CMD_OFS, 32'h4);
      rd(WSPC_RX_DESCRIPTOR_POINTER_OFS, 32'h3000);
      check(32'(rx_enabled), 32'h1);
      check(32'(reloads), 32'h4);
      close_out();
   end
endmodule : wspc_power_ctrl_tb
bind wspc_power_ctrl wspc_power_ctrl_sva chk (.ref_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wake_signal_pin_n, .wake_signal_pin_oe,
   .rx_enabled, .rx_drain_start, .remote_wake_mode, .sleep_mode, .phy_power_on);
`default_nettype wire
